// [lmc_assertions.sv]
module lmc_assertions (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Link request
   input wire logic req_valid,
   input wire logic req_mem,
   input wire logic req_write,
   input wire logic [31:0] req_addr,
   // Link answer
   input wire logic rsp_valid,
   input wire logic rsp_claimed,
   input wire logic [7:0] rsp_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   property p_io_rsp;
      req_valid && !req_mem |=> rsp_valid;
   endproperty
   a_io_rsp: assert property (p_io_rsp) else $error("io answer late");
   property p_mem_rsp;
      req_valid && req_mem |-> ##[1:8] rsp_valid;
   endproperty
   a_mem_rsp: assert property (p_mem_rsp) else $error("mem answer lost");
   property p_rsp_pulse;
      rsp_valid |=> !rsp_valid;
   endproperty
   a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer held");
   property p_req_gap;
      req_valid |=> !req_valid;
   endproperty
   a_req_gap: assert property (p_req_gap) else $error("req overlap");
   property p_unclaimed_ff;
      rsp_valid && !rsp_claimed |-> rsp_rdata == 8'hFF;
   endproperty
   a_unclaimed_ff: assert property (p_unclaimed_ff)
      else $error("bad idle byte");
   property p_fast_unclaimed;
      req_valid && req_mem ##1 rsp_valid |-> !rsp_claimed;
   endproperty
   a_fast_unclaimed: assert property (p_fast_unclaimed)
      else $error("no bus trip");
   property p_mem_claim;
      req_valid && req_mem ##1 !rsp_valid |->
         ##[1:7] (rsp_valid && rsp_claimed);
   endproperty
   a_mem_claim: assert property (p_mem_claim)
      else $error("slow not claimed");
   property p_ec_rsv;
      req_valid && !req_mem && !req_write && req_addr[15:4] == 12'h003
         && req_addr[2:1] == 2'b11 |=> rsp_claimed && rsp_rdata == 8'h00;
   endproperty
   a_ec_rsv: assert property (p_ec_rsv) else $error("rsv byte bad");

   // Main scenarios reached
   c_mem_claim: cover property (rsp_valid && rsp_claimed && req_mem);
   c_unclaimed: cover property (rsp_valid && !rsp_claimed);
   c_ec_rsv: cover property (req_valid && req_addr[15:0] == 16'h003F);
endmodule // lmc_assertions

// [lmc_device.sv]
// What this block does
// - Memory cycles single byte, 32-bit address
// - Check all windows together, claim any match
// - Double hit sets sticky overlap flag
// - Host keeps windows from overlapping
// - Window register is 48 bits wide
// - One byte AHB transfer per memory claim
// - Match needs valid and masked address equal
// - AHB address: base high, LPC low bits
// - SRAM window claims only while valid
// - SRAM window at most 4 kB
// - Firmware aligns SRAM base to size
// - Size limits claims and internal reach
// - Index and data work only in mode
// - Index selects byte, data accesses it
// - Unwritten index reads location 00h
// - Index base+0, data base+1, base reset 2Eh
// - Port base relocated through index 60h (high byte) and 61h (low byte)
// - Key 55h enters configuration mode
// - Key AAh leaves configuration mode
// - Any reset forces configuration mode off
// - Host enters, programs, then leaves mode
// - EC blocks decode eight I/O bytes
module lmc_device
   import lmc_pkg::*;
(
   // Clock and resets
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic chip_system_reset_n,
   input wire logic host_side_reset_n,
   // Link
   lmc_link_if.device link,
   // Firmware window setup
   input wire logic [NUM_WIN-1:0][WIN_W-1:0] win_cfg,
   input wire logic [31:0] sram_base,
   input wire logic [SIZE_W-1:0] sram_size,
   input wire logic sram_valid,
   input wire logic overlap_clear,
   output logic bus_err_overlap,
   output logic cfg_mode,
   // EC instances
   input wire logic [NUM_EC-1:0][7:0] ec_status,
   output logic [NUM_EC-1:0][3:0][7:0] host_data_byte,
   output logic [NUM_EC-1:0][7:0] host_byte_count_control,
   output logic [NUM_EC-1:0] host_command_write,
   output logic [7:0] ec_cmd_byte,
   // AHB-lite master
   output logic [1:0] htrans,
   output logic [31:0] haddr,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata
);
   import lmc_pkg::*;

   typedef struct packed {
      lmc_dev_st_t st;
      logic cfg_mode;
      logic [7:0] index;
      logic [NUM_CFG_LO-1:0][7:0] cfg_lo;
      logic [7:0] base_hi;
      logic [7:0] base_lo;
      logic [3:0][7:0] sram_host;
      logic [NUM_EC-1:0][3:0][7:0] ec_data;
      logic [NUM_EC-1:0][7:0] ec_ctl;
      logic [7:0] ec_cmd;
      logic [NUM_EC-1:0] ec_cmd_stb;
      logic overlap;
      logic [1:0] htrans;
      logic [31:0] haddr;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic [7:0] wbyte;
      logic rsp_valid;
      logic rsp_claimed;
      logic [7:0] rsp_rdata;
   } lmc_dev_state_t;

   localparam lmc_dev_state_t DEV_RST = '{st: D_IDLE,
      base_hi: CFG_PORT_BASE_RST[15:8], base_lo: CFG_PORT_BASE_RST[7:0],
      hsize: HSIZE_BYTE, htrans: HTRANS_IDLE, index: CFG_IDX_RST,
      default: '0};

   lmc_dev_state_t r, n;

   logic [NUM_WIN:0] hit;
   logic [NUM_WIN:0][31:0] map_addr;
   logic [31:0] sel_addr;
   logic multi_hit;
   logic [15:0] port_base;
   logic is_index;
   logic is_data;
   logic [NUM_EC-1:0] ec_hit;
   logic [7:0] cfg_rd;

   // Address decode, all windows in parallel
   always_comb begin
      logic [31:0] m;
      logic [SIZE_W-1:0] sz;
      logic [31:0] a;
      m = '0;
      sz = '0;
      a = link.req_addr;
      for (int i = 0; i < NUM_WIN; i++) begin
         sz = win_cfg[i][WIN_SIZE_LSB +: SIZE_W];
         m = size_mask(sz);
         hit[i] = win_cfg[i][WIN_VALID] &&
            ((a & ~m) == (win_cfg[i][WIN_HOST_LSB +: 32] & ~m));
         // only low bits come from LPC
         map_addr[i] = ({AHB_REGION, win_cfg[i][WIN_PAGE_LSB +: PAGE_W],
            PAGE_PAD} & ~m) | (a & m);
      end
      sz = (sram_size > SRAM_MAX_SIZE) ? SRAM_MAX_SIZE : sram_size;
      m = size_mask(sz);
      hit[NUM_WIN] = sram_valid &&
         ((a & ~m) == (32'(r.sram_host) & ~m));
      map_addr[NUM_WIN] = (sram_base & ~m) | (a & m);
      sel_addr = map_addr[NUM_WIN];
      for (int i = NUM_WIN - 1; i >= 0; i--) begin
         if (hit[i]) begin
            sel_addr = map_addr[i];
         end
      end
      multi_hit = |(hit & (hit - 1'b1));
      // index at base, data at base plus one
      port_base = {r.base_hi, r.base_lo};
      is_index = (a[15:0] == port_base);
      is_data = (a[15:0] == port_base + CFG_DATA_OFS);
      for (int e = 0; e < NUM_EC; e++) begin
         ec_hit[e] = ((a[15:0] & ~EC_MASK) == (EC_BASES[e] & ~EC_MASK));
      end
      if (r.index[7:4] == IDX_LO_GRP) begin
         cfg_rd = r.cfg_lo[r.index[3:0]];
      end else if (r.index == IDX_BASE_HI) begin
         cfg_rd = r.base_hi;
      end else if (r.index == IDX_BASE_LO) begin
         cfg_rd = r.base_lo;
      end else if (r.index[7:2] == IDX_SRAM_GRP) begin
         cfg_rd = r.sram_host[r.index[1:0]];
      end else begin
         cfg_rd = BYTE_ZERO;
      end
   end

   // Next state
   always_comb begin
      logic [2:0] ofs;
      ofs = link.req_addr[2:0];
      n = r;
      n.rsp_valid = 1'b0;
      n.ec_cmd_stb = '0;
      if (overlap_clear) begin
         n.overlap = 1'b0;
      end
      case (r.st)
         D_IDLE: begin
            if (link.req_valid && link.req_mem) begin
               if (|hit) begin
                  // set after clear so it wins
                  if (multi_hit) begin
                     n.overlap = 1'b1;
                  end
                  n.st = D_ADDR;
                  n.htrans = HTRANS_NONSEQ;
                  n.haddr = sel_addr;
                  n.hwrite = link.req_write;
                  n.wbyte = link.req_wdata;
               end else begin
                  n.rsp_valid = 1'b1;
                  n.rsp_claimed = 1'b0;
                  n.rsp_rdata = DATA_UNDEF;
               end
            end else if (link.req_valid) begin
               n.rsp_valid = 1'b1;
               n.rsp_claimed = 1'b0;
               n.rsp_rdata = DATA_UNDEF;
               if (is_index) begin
                  n.rsp_claimed = 1'b1;
                  if (link.req_write) begin
                     if (!r.cfg_mode && link.req_wdata == KEY_ENTRY) begin
                        n.cfg_mode = 1'b1;
                     end else if (r.cfg_mode &&
                                  link.req_wdata == KEY_EXIT) begin
                        n.cfg_mode = 1'b0;
                     end else if (r.cfg_mode) begin
                        n.index = link.req_wdata;
                     end
                  end else if (r.cfg_mode) begin
                     n.rsp_rdata = r.index;
                  end
               end else if (is_data) begin
                  n.rsp_claimed = 1'b1;
                  if (r.cfg_mode && !link.req_write) begin
                     n.rsp_rdata = cfg_rd;
                  end else if (r.cfg_mode) begin
                     if (r.index[7:4] == IDX_LO_GRP) begin
                        n.cfg_lo[r.index[3:0]] = link.req_wdata;
                     end else if (r.index == IDX_BASE_HI) begin
                        n.base_hi = link.req_wdata;
                     end else if (r.index == IDX_BASE_LO) begin
                        n.base_lo = link.req_wdata;
                     end else if (r.index[7:2] == IDX_SRAM_GRP) begin
                        n.sram_host[r.index[1:0]] = link.req_wdata;
                     end
                  end
               end else begin
                  for (int e = 0; e < NUM_EC; e++) begin
                     if (ec_hit[e]) begin
                        n.rsp_claimed = 1'b1;
                        n.rsp_rdata = BYTE_ZERO;
                        if (ofs <= EC_OFS_DATA_LAST) begin
                           n.rsp_rdata = r.ec_data[e][ofs[1:0]];
                           if (link.req_write) begin
                              n.ec_data[e][ofs[1:0]] = link.req_wdata;
                           end
                        end else if (ofs == EC_OFS_CMD) begin
                           n.rsp_rdata = ec_status[e];
                           if (link.req_write) begin
                              n.ec_cmd = link.req_wdata;
                              n.ec_cmd_stb[e] = 1'b1;
                           end
                        end else if (ofs == EC_OFS_CTL) begin
                           n.rsp_rdata = r.ec_ctl[e];
                           if (link.req_write) begin
                              n.ec_ctl[e] = link.req_wdata;
                           end
                        end
                     end
                  end
               end
            end
         end
         D_ADDR: begin
            if (hready) begin
               n.st = D_DATA;
               n.htrans = HTRANS_IDLE;
               n.hwdata = {4{r.wbyte}};
            end
         end
         D_DATA: begin
            if (hready) begin
               n.st = D_IDLE;
               n.rsp_valid = 1'b1;
               n.rsp_claimed = 1'b1;
               n.rsp_rdata = hrdata[{r.haddr[1:0], 3'b000} +: 8];
            end
         end
         default: begin
            n.st = D_IDLE;
            n.htrans = HTRANS_IDLE;
         end
      endcase
      // every reset source clears the mode
      if (!chip_system_reset_n || !host_side_reset_n ||
          !link.link_reset_n) begin
         n.cfg_mode = 1'b0;
      end
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         r <= DEV_RST;
      end else begin
         r <= n;
      end
   end

   // Outputs straight from the state register
   assign link.rsp_valid = r.rsp_valid;
   assign link.rsp_claimed = r.rsp_claimed;
   assign link.rsp_rdata = r.rsp_rdata;
   assign bus_err_overlap = r.overlap;
   assign cfg_mode = r.cfg_mode;
   assign host_data_byte = r.ec_data;
   assign host_byte_count_control = r.ec_ctl;
   assign host_command_write = r.ec_cmd_stb;
   assign ec_cmd_byte = r.ec_cmd;
   assign htrans = r.htrans;
   assign haddr = r.haddr;
   assign hwrite = r.hwrite;
   assign hsize = r.hsize;
   assign hwdata = r.hwdata;

endmodule // lmc_device

// [lmc_host.sv]
module lmc_host
   import lmc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Link
   lmc_link_if.host link,
   // Command port
   input wire logic cmd_valid,
   input wire lmc_pkg::lmc_op_t cmd_op,
   input wire logic [31:0] cmd_addr,
   input wire logic [7:0] cmd_index,
   input wire logic [7:0] cmd_wdata,
   input wire logic [15:0] cfg_port_base,
   input wire logic link_reset_req,
   output logic cmd_ready,
   output logic done,
   output logic done_claimed,
   output logic [7:0] done_rdata
);
   import lmc_pkg::*;

   typedef struct packed {
      logic mem;
      logic write;
      logic [31:0] addr;
      logic [7:0] wdata;
   } lmc_req_t;

   typedef struct packed {
      lmc_host_st_t st;
      lmc_op_t op;
      logic [1:0] step;
      logic [31:0] addr;
      logic [7:0] index;
      logic [7:0] wdata;
      logic [15:0] base;
      logic acc;
      logic [7:0] rdata;
      logic lreset_n;
      logic req_valid;
      lmc_req_t req;
      logic cmd_ready;
      logic done;
      logic done_claimed;
      logic [7:0] done_rdata;
   } lmc_host_state_t;

   localparam lmc_host_state_t HOST_RST = '{st: H_IDLE, op: OP_MEM_RD,
      lreset_n: 1'b1, cmd_ready: 1'b1, default: '0};

   lmc_host_state_t r, n;

   // One link request for a command and a configuration step
   function automatic lmc_req_t build_req(input lmc_op_t op,
      input logic [1:0] step, input logic [31:0] addr,
      input logic [7:0] idx, input logic [7:0] wd, input logic [15:0] base);
      lmc_req_t q;
      q = '{mem: 1'b0, write: 1'b0, addr: addr, wdata: wd};
      case (op)
         OP_MEM_RD, OP_MEM_WR: begin
            q.mem = 1'b1;
            q.write = (op == OP_MEM_WR);
         end
         OP_IO_RD, OP_IO_WR: begin
            q.write = (op == OP_IO_WR);
            q.addr = {16'h0000, addr[15:0]};
         end
         default: begin
            q.addr = {16'h0000, base};
            q.write = 1'b1;
            case (step)
               STEP_ENTRY: q.wdata = KEY_ENTRY;
               STEP_INDEX: q.wdata = idx;
               STEP_DATA: begin
                  q.addr = {16'h0000, base + CFG_DATA_OFS};
                  q.write = (op == OP_CFG_WR);
               end
               default: q.wdata = KEY_EXIT;
            endcase
         end
      endcase
      return q;
   endfunction

   // Next state
   always_comb begin
      n = r;
      n.req_valid = 1'b0;
      n.done = 1'b0;
      n.lreset_n = ~link_reset_req;
      case (r.st)
         H_IDLE: begin
            if (cmd_valid) begin
               n.st = H_WAIT;
               n.cmd_ready = 1'b0;
               n.op = cmd_op;
               n.addr = cmd_addr;
               n.index = cmd_index;
               n.wdata = cmd_wdata;
               n.base = cfg_port_base;
               n.step = STEP_ENTRY;
               n.acc = 1'b1;
               n.rdata = BYTE_ZERO;
               n.req_valid = 1'b1;
               n.req = build_req(cmd_op, STEP_ENTRY, cmd_addr, cmd_index,
                  cmd_wdata, cfg_port_base);
            end
         end
         H_WAIT: begin
            if (link.rsp_valid) begin
               n.acc = r.acc & link.rsp_claimed;
               if (r.op < OP_CFG_RD || r.step == STEP_DATA) begin
                  n.rdata = link.rsp_rdata;
               end
               if (r.op >= OP_CFG_RD && r.step != STEP_EXIT) begin
                  n.step = r.step + 2'h1;
                  n.req_valid = 1'b1;
                  n.req = build_req(r.op, n.step, r.addr, r.index,
                     r.wdata, r.base);
               end else begin
                  n.st = H_IDLE;
                  n.cmd_ready = 1'b1;
                  n.done = 1'b1;
                  n.done_claimed = n.acc;
                  n.done_rdata = n.rdata;
               end
            end
         end
         default: n.st = H_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         r <= HOST_RST;
      end else begin
         r <= n;
      end
   end

   // Outputs straight from the state register
   assign link.req_valid = r.req_valid;
   assign link.req_mem = r.req.mem;
   assign link.req_write = r.req.write;
   assign link.req_addr = r.req.addr;
   assign link.req_wdata = r.req.wdata;
   assign link.link_reset_n = r.lreset_n;
   assign cmd_ready = r.cmd_ready;
   assign done = r.done;
   assign done_claimed = r.done_claimed;
   assign done_rdata = r.done_rdata;

endmodule // lmc_host

// [lmc_link_if.sv]
interface lmc_link_if;
   import lmc_pkg::*;

   // Cycle request, one-cycle pulse from the host
   logic req_valid;
   logic req_mem;
   logic req_write;
   logic [31:0] req_addr;
   logic [7:0] req_wdata;
   // Link reset, low while asserted
   logic link_reset_n;
   // Answer, one-cycle pulse from the device
   logic rsp_valid;
   logic rsp_claimed;
   logic [7:0] rsp_rdata;

   modport host (
      output req_valid, req_mem, req_write, req_addr, req_wdata,
      output link_reset_n,
      input rsp_valid, rsp_claimed, rsp_rdata
   );

   modport device (
      input req_valid, req_mem, req_write, req_addr, req_wdata,
      input link_reset_n,
      output rsp_valid, rsp_claimed, rsp_rdata
   );

endinterface

// [lmc_pkg.sv]
package lmc_pkg;

   // Instance counts
   localparam int NUM_WIN = 2;
   localparam int NUM_EC = 2;
   localparam int NUM_CFG_LO = 16;

   // Configuration port keys, reset values and index map
   localparam logic [15:0] CFG_PORT_BASE_RST = 16'h002E;
   localparam logic [15:0] CFG_DATA_OFS = 16'h0001;
   localparam logic [7:0] KEY_ENTRY = 8'h55;
   localparam logic [7:0] KEY_EXIT = 8'hAA;
   localparam logic [7:0] CFG_IDX_RST = 8'h00;
   localparam logic [7:0] IDX_BASE_HI = 8'h60;
   localparam logic [7:0] IDX_BASE_LO = 8'h61;
   localparam logic [5:0] IDX_SRAM_GRP = 6'h3C;
   localparam logic [3:0] IDX_LO_GRP = 4'h0;
   localparam logic [7:0] DATA_UNDEF = 8'hFF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // Extra EC instances: 8-byte blocks
   localparam logic [NUM_EC-1:0][15:0] EC_BASES = {16'h0038, 16'h0030};
   localparam logic [15:0] EC_MASK = 16'h0007;
   localparam logic [2:0] EC_OFS_DATA_LAST = 3'h3;
   localparam logic [2:0] EC_OFS_CMD = 3'h4;
   localparam logic [2:0] EC_OFS_CTL = 3'h5;

   // 48-bit memory window layout
   localparam int WIN_W = 48;
   localparam int WIN_VALID = 0;
   localparam int WIN_SIZE_LSB = 1;
   localparam int SIZE_W = 4;
   localparam int WIN_PAGE_LSB = 5;
   localparam int PAGE_W = 11;
   localparam int WIN_HOST_LSB = 16;
   localparam logic [8:0] AHB_REGION = 9'h001;
   localparam logic [11:0] PAGE_PAD = 12'h000;
   localparam logic [SIZE_W-1:0] SRAM_MAX_SIZE = 4'hC;

   // AHB-lite codes
   localparam logic [1:0] HTRANS_IDLE = 2'b00;
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [2:0] HSIZE_BYTE = 3'b000;

   // Host configuration sequence steps
   localparam logic [1:0] STEP_ENTRY = 2'h0;
   localparam logic [1:0] STEP_INDEX = 2'h1;
   localparam logic [1:0] STEP_DATA = 2'h2;
   localparam logic [1:0] STEP_EXIT = 2'h3;

   typedef enum logic [1:0] {
      D_IDLE = 2'b00,
      D_ADDR = 2'b01,
      D_DATA = 2'b11
   } lmc_dev_st_t;

   typedef enum logic {
      H_IDLE = 1'b0,
      H_WAIT = 1'b1
   } lmc_host_st_t;

   typedef enum logic [2:0] {
      OP_MEM_RD = 3'h0,
      OP_MEM_WR = 3'h1,
      OP_IO_RD = 3'h2,
      OP_IO_WR = 3'h3,
      OP_CFG_RD = 3'h4,
      OP_CFG_WR = 3'h5
   } lmc_op_t;

   // Mask of the low window bits: 2^size - 1
   function automatic logic [31:0] size_mask(input logic [SIZE_W-1:0] s);
      return (32'h0000_0001 << s) - 32'h0000_0001;
   endfunction

endpackage

// [lpc_memory_claim_config_port_tb.sv]
module lpc_memory_claim_config_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import lmc_pkg::*;

   logic core_clk = 1'b0;
   logic sys_rst, chip_system_reset_n, host_side_reset_n, link_reset_req;
   logic cmd_valid, sram_valid, overlap_clear, hready, hwrite, cl;
   logic cmd_ready, done, done_claimed, bus_err_overlap, cfg_mode;
   lmc_op_t cmd_op;
   logic [31:0] cmd_addr, sram_base, hrdata, haddr, hwdata, last_haddr;
   logic [7:0] cmd_index, cmd_wdata, done_rdata, ec_cmd_byte, rd;
   logic [15:0] cfg_port_base;
   logic [NUM_WIN-1:0][WIN_W-1:0] win_cfg;
   logic [SIZE_W-1:0] sram_size;
   logic [NUM_EC-1:0][7:0] ec_status, host_byte_count_control;
   logic [NUM_EC-1:0][3:0][7:0] host_data_byte;
   logic [NUM_EC-1:0] host_command_write;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int err_count = 0, n_compared = 0, n_ahb = 0, n_cmdw = 0;

   lmc_link_if link ();
   lmc_host lmc_host_i (.core_clk(core_clk), .sys_rst(sys_rst), .link(link),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
      .cmd_index(cmd_index), .cmd_wdata(cmd_wdata),
      .cfg_port_base(cfg_port_base), .link_reset_req(link_reset_req),
      .cmd_ready(cmd_ready), .done(done), .done_claimed(done_claimed),
      .done_rdata(done_rdata));
   lmc_device lmc_device_i (.core_clk(core_clk), .sys_rst(sys_rst),
      .chip_system_reset_n(chip_system_reset_n),
      .host_side_reset_n(host_side_reset_n), .link(link), .win_cfg(win_cfg),
      .sram_base(sram_base), .sram_size(sram_size), .sram_valid(sram_valid),
      .overlap_clear(overlap_clear), .bus_err_overlap(bus_err_overlap),
      .cfg_mode(cfg_mode), .ec_status(ec_status),
      .host_data_byte(host_data_byte),
      .host_byte_count_control(host_byte_count_control),
      .host_command_write(host_command_write), .ec_cmd_byte(ec_cmd_byte),
      .htrans(htrans), .haddr(haddr), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
   lmc_assertions lmc_assertions_i (.core_clk(core_clk), .sys_rst(sys_rst),
      .req_valid(link.req_valid), .req_mem(link.req_mem),
      .req_write(link.req_write), .req_addr(link.req_addr),
      .rsp_valid(link.rsp_valid), .rsp_claimed(link.rsp_claimed),
      .rsp_rdata(link.rsp_rdata));

   always #10 core_clk = ~core_clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Bus beats; lane 1 strobes weigh 16
   always @(posedge core_clk) begin
      if (htrans == HTRANS_NONSEQ) begin
         n_ahb++;
         last_haddr <= haddr;
         check(hsize, HSIZE_BYTE);
      end
      n_cmdw += host_command_write[0] + 16 * host_command_write[1];
   end

   // One command; cfg index is the low address byte
   task automatic op(input lmc_op_t o, input logic [31:0] a,
                     input logic [7:0] d);
      int n;
      @(negedge core_clk);
      cmd_valid = 1'b1;
      cmd_op = o;
      cmd_addr = a;
      cmd_index = a[7:0];
      cmd_wdata = d;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      check(cmd_ready, 1'b0);
      n = 0;
      while (done !== 1'b1 && n < 60) begin
         @(negedge core_clk);
         n++;
      end
      if (n == 60) check(1'b0, 1'b1);
      cl = done_claimed;
      rd = done_rdata;
   endtask

   task automatic t_cfg;
      check({bus_err_overlap, cfg_mode}, 2'b00);
      op(OP_IO_WR, 32'h2E, KEY_ENTRY);
      check(cfg_mode, 1'b1);
      op(OP_IO_RD, 32'h2E, 8'h00);
      check(rd, 8'h00);
      op(OP_IO_RD, 32'h2F, 8'h00);
      check(rd, 8'h00);
      op(OP_IO_WR, 32'h2E, 8'h05);
      op(OP_IO_WR, 32'h2F, 8'hA5);
      op(OP_IO_RD, 32'h2F, 8'h00);
      check(rd, 8'hA5);
      op(OP_IO_WR, 32'h2E, KEY_ENTRY);
      op(OP_IO_RD, 32'h2E, 8'h00);
      check({cfg_mode, rd}, {1'b1, KEY_ENTRY});
      op(OP_IO_WR, 32'h2E, KEY_EXIT);
      op(OP_IO_RD, 32'h2F, 8'h00);
      check({cfg_mode, cl, rd}, {2'b01, DATA_UNDEF});
      op(OP_IO_WR, 32'h2E, KEY_EXIT);
      check(cfg_mode, 1'b0);
      $display("config port test done");
   endtask

   // Exit key of this op misses the moved index
   task automatic t_reloc;
      op(OP_CFG_WR, 32'h60, 8'h00);
      op(OP_CFG_WR, 32'h61, 8'h4E);
      check(cfg_mode, 1'b1);
      op(OP_IO_WR, 32'h4E, KEY_EXIT);
      cfg_port_base = 16'h004E;
      op(OP_CFG_RD, 32'h05, 8'h00);
      check({cfg_mode, rd}, {1'b0, 8'hA5});
      $display("relocation test done");
   endtask

   task automatic t_reset;
      for (int k = 0; k < 3; k++) begin
         op(OP_IO_WR, 32'h4E, KEY_ENTRY);
         check(cfg_mode, 1'b1);
         chip_system_reset_n = (k != 0);
         host_side_reset_n = (k != 1);
         link_reset_req = (k == 2);
         repeat (3) @(negedge core_clk);
         check(cfg_mode, 1'b0);
         chip_system_reset_n = 1'b1;
         host_side_reset_n = 1'b1;
         link_reset_req = 1'b0;
         repeat (2) @(negedge core_clk);
      end
      $display("reset test done");
   endtask

   task automatic t_win;
      int a0;
      a0 = n_ahb;
      win_cfg[0] = {32'h8000_1000, 11'h123, 4'h4, 1'b1};
      win_cfg[1] = {32'h9000_0000, 11'h456, 4'h8, 1'b1};
      op(OP_MEM_WR, 32'h8000_1005, 8'h3C);
      check({cl, hwrite}, 2'b11);
      check(hwdata, 32'h3C3C_3C3C);
      check(last_haddr, 32'h0092_3005);
      op(OP_MEM_RD, 32'h8000_100A, 8'h00);
      check({cl, rd}, {1'b1, 8'hCC});
      op(OP_MEM_RD, 32'h9000_0033, 8'h00);
      check(last_haddr, 32'h00C5_6033);
      op(OP_MEM_RD, 32'h8000_1010, 8'h00);
      check({cl, rd}, {1'b0, 8'hFF});
      win_cfg[0][WIN_VALID] = 1'b0;
      op(OP_MEM_RD, 32'h8000_1001, 8'h00);
      check(cl, 1'b0);
      check(n_ahb - a0, 3);
      $display("window test done");
   endtask

   // Size over 4 kB clamps: 8000_7000 unclaimed
   task automatic t_sram;
      logic [31:0] h;
      h = 32'h8000_2000;
      for (int i = 0; i < 4; i++) op(OP_CFG_WR, 32'hF0 + i, h[8*i +: 8]);
      sram_base = 32'h0002_0000;
      sram_size = 4'hF;
      op(OP_MEM_RD, 32'h8000_2ABC, 8'h00);
      check(cl, 1'b0);
      sram_valid = 1'b1;
      op(OP_MEM_RD, 32'h8000_2ABC, 8'h00);
      check(cl, 1'b1);
      check(last_haddr, 32'h0002_0ABC);
      op(OP_MEM_RD, 32'h8000_7000, 8'h00);
      check({cl, bus_err_overlap}, 2'b00);
      win_cfg[1] = {32'h8000_2000, 11'h001, 4'h4, 1'b1};
      op(OP_MEM_RD, 32'h8000_2004, 8'h00);
      check({cl, bus_err_overlap}, 2'b11);
      check(last_haddr, 32'h0080_1004);
      overlap_clear = 1'b1;
      @(negedge core_clk);
      overlap_clear = 1'b0;
      @(negedge core_clk);
      check(bus_err_overlap, 1'b0);
      $display("sram window test done");
   endtask

   task automatic t_ec;
      logic [15:0] b;
      int c0;
      for (int k = 0; k < NUM_EC; k++) begin
         b = EC_BASES[k];
         op(OP_IO_WR, b + 3, 8'hD3);
         op(OP_IO_RD, b + 3, 8'h00);
         check({host_data_byte[k][3], rd}, 16'hD3D3);
         c0 = n_cmdw;
         op(OP_IO_WR, b + 4, 8'h9C);
         check(ec_cmd_byte, 8'h9C);
         check(n_cmdw - c0, k ? 16 : 1);
         op(OP_IO_RD, b + 4, 8'h00);
         check(rd, ec_status[k]);
         op(OP_IO_WR, b + 5, 8'h77);
         check(host_byte_count_control[k], 8'h77);
         op(OP_IO_RD, b + 7, 8'h00);
         check({cl, rd}, 9'h100);
      end
      op(OP_IO_RD, 32'h40, 8'h00);
      check(cl, 1'b0);
      $display("ec block test done");
   endtask

   // Watchdog: tests need under 3000 cycles
   initial begin
      #200us;
      err_count++;
      wrap_up();
   end

   initial begin
      sys_rst = 1'b1;
      chip_system_reset_n = 1'b1;
      host_side_reset_n = 1'b1;
      link_reset_req = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = OP_IO_RD;
      cmd_addr = 32'h0000_0000;
      cmd_index = 8'h00;
      cmd_wdata = 8'h00;
      cfg_port_base = 16'h002E;
      win_cfg = '0;
      sram_base = 32'h0000_0000;
      sram_size = 4'h0;
      sram_valid = 1'b0;
      overlap_clear = 1'b0;
      ec_status = 16'h6A5A;
      hready = 1'b1;
      hrdata = 32'hDDCC_BBAA;
      repeat (3) @(negedge core_clk);
      sys_rst = 1'b0;
      t_cfg();
      t_reloc();
      t_reset();
      t_win();
      t_sram();
      t_ec();
      wrap_up();
   end
endmodule // lpc_memory_claim_config_port_tb
